// >>> design/lcs_control_status.sv
// Control and status logic of a LIN master/slave controller behind an indirect pointer and data port.
// ============================================================================
// What this block does
// - Stop strobe blocks slave processing until break.
// - Sleep bit enters sleep on command/idle.
// - Sleep bit low leaves sleep on wakeup.
// - Direction bit: 1 transmit, 0 receive.
// - Software acks data request; controller self-clears.
// - Interrupt clear strobe clears pending flag.
// - Fault clear strobe clears error and causes.
// - Wake request sends wakeup, then self-clears.
// - Start request clears on completion or error.
// - Activity flag follows bus activity.
// - Idle flag after four quiet seconds, slave.
// - Abort on early break or stop.
// - Abort clears on non-interrupting break.
// - Data request flag set on identifier.
// - Pending flag holds until interrupt clear.
// - Error flag set; cleared only by strobe.
// - Wakeup flag while sending or after receiving.
// - Done clears at start, sets at finish.
// - Start master-only; several bits slave-only.
// - Role bit: 0 slave, 1 master.
// - Data port reaches register the pointer selects.
module lcs_control_status
  import lcs_pkg::*;
#(
  parameter longint IDLE_CYCLES = LCS_IDLE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  // Register access.
  input wire logic config_wr,
  input wire logic pointer_wr,
  input wire logic port_wr,
  input wire logic port_rd,
  input wire logic [7:0] wr_data,
  output logic [7:0] config_data,
  output logic [7:0] pointer_data,
  output logic [7:0] port_data,
  // Events from the frame engine.
  input wire logic bus_active,
  input wire logic break_seen,
  input wire logic ident_received,
  input wire logic frame_finished,
  input wire logic [LCS_FAULT_BITS-1:0] fault_event,
  input wire logic sleep_frame_seen,
  input wire logic wakeup_seen,
  input wire logic wake_tx_busy,
  input wire logic wake_tx_finished,
  // Commands to the frame engine.
  output logic link_enable,
  output logic master_mode,
  output logic direction_select,
  output logic frame_launch,
  output logic data_ack_pulse,
  output logic wake_launch,
  output logic processing_blocked,
  output logic sleep_mode,
  output logic irq
);

  // ==========================================================================
  // Registers and decoded strobes
  logic [7:0] config_reg, indirect_pointer, link_control, link_status, next_port_data;
  logic [LCS_FAULT_BITS-1:0] fault_cause_register;
  logic sleep_ctl, data_ack_strobe, wake_request, frame_start_request, idle_timeout_flag, abort_flag;
  logic data_request_flag, pending_irq_flag, fault_flag, wakeup_rx_flag, done_flag, frame_busy;
  logic ctl_wr, slave, stop_wr, irq_clear_strobe, fault_clear_strobe, any_fault, slave_break, frame_begin;
  logic idle_expired_q, idle_rise;

  lcs_idle_if idle ();

  lcs_idle_timer #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .idle(idle.timer)
  );

  assign ctl_wr = port_wr && (indirect_pointer == LCS_IDX_CONTROL);
  assign slave = !config_reg[LCS_CFG_MASTER];
  assign stop_wr = ctl_wr && slave && wr_data[LCS_CTL_STOP];
  assign irq_clear_strobe = ctl_wr && wr_data[LCS_CTL_IRQCLR];
  assign fault_clear_strobe = ctl_wr && wr_data[LCS_CTL_FAULTCLR];
  assign any_fault = |fault_event;
  // Processing blocked by the stop strobe ignores received identifiers until a break arrives.
  assign slave_break = break_seen && slave;
  assign frame_begin = frame_launch || (break_seen && !sleep_mode);

  assign link_enable = config_reg[LCS_CFG_ENABLE];
  assign master_mode = config_reg[LCS_CFG_MASTER];
  assign irq = pending_irq_flag;

  // ==========================================================================
  // Mode configuration and indirect pointer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      config_reg <= LCS_CONFIG_RESET;
    end else if (config_wr) begin
      config_reg <= wr_data & LCS_CONFIG_MASK;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      indirect_pointer <= 8'h00;
    end else if (pointer_wr) begin
      indirect_pointer <= wr_data;
    end
  end

  assign config_data = config_reg;
  assign pointer_data = indirect_pointer;

  // ==========================================================================
  // Control register bits held in storage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_ctl <= 1'b0;
      direction_select <= 1'b0;
    end else if (ctl_wr) begin
      if (slave) begin
        sleep_ctl <= wr_data[LCS_CTL_SLEEP];
      end
      direction_select <= wr_data[LCS_CTL_DIR];
    end
  end

  // The acknowledge bit is seen by the engine as a one-cycle pulse and then drops by itself.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      data_ack_strobe <= 1'b0;
    end else if (ctl_wr && slave && wr_data[LCS_CTL_ACK]) begin
      data_ack_strobe <= 1'b1;
    end else begin
      data_ack_strobe <= 1'b0;
    end
  end

  assign data_ack_pulse = data_ack_strobe;

  // ==========================================================================
  // Wake request
  // The request stays set while the wakeup signal goes out, so software can poll it.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wake_request <= 1'b0;
    end else if (ctl_wr && wr_data[LCS_CTL_WAKE] && !wake_request) begin
      wake_request <= 1'b1;
    end else if (wake_tx_finished) begin
      wake_request <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wake_launch <= 1'b0;
    end else begin
      wake_launch <= ctl_wr && wr_data[LCS_CTL_WAKE] && !wake_request;
    end
  end

  // ==========================================================================
  // Start request and frame launch
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frame_start_request <= 1'b0;
      frame_launch <= 1'b0;
    end else begin
      frame_launch <= 1'b0;
      if (frame_start_request && (frame_finished || any_fault)) begin
        frame_start_request <= 1'b0;
      end else if (ctl_wr && !slave && wr_data[LCS_CTL_START] && !frame_start_request) begin
        // Software is expected to have loaded identifier, size and data first.
        frame_start_request <= 1'b1;
        frame_launch <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Frame tracking and processing block
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frame_busy <= 1'b0;
    end else if (frame_begin) begin
      frame_busy <= 1'b1;
    end else if (frame_finished || any_fault || stop_wr) begin
      frame_busy <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      processing_blocked <= 1'b0;
    end else if (break_seen) begin
      processing_blocked <= 1'b0;
    end else if (stop_wr) begin
      processing_blocked <= 1'b1;
    end
  end

  // ==========================================================================
  // Sleep mode
  // Leaving sleep through a sent wakeup is allowed in either role; the sleep bit gates slave entry and exit on a received wakeup.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_mode <= 1'b0;
    end else if (sleep_mode) begin
      if ((slave && !sleep_ctl && wakeup_seen) || wake_tx_finished) begin
        sleep_mode <= 1'b0;
      end
    end else if (slave && sleep_ctl && (sleep_frame_seen || idle_timeout_flag)) begin
      sleep_mode <= 1'b1;
    end
  end

  // ==========================================================================
  // Idle timeout
  assign idle.run = slave && !sleep_mode;
  assign idle.activity = bus_active;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      idle_expired_q <= 1'b0;
    end else begin
      idle_expired_q <= idle.expired;
    end
  end

  assign idle_rise = idle.expired && !idle_expired_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      idle_timeout_flag <= 1'b0;
    end else begin
      idle_timeout_flag <= idle.expired && slave && !sleep_mode;
    end
  end

  // ==========================================================================
  // Abort, data request and done flags
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      abort_flag <= 1'b0;
    end else if (!slave) begin
      abort_flag <= 1'b0;
    end else if (stop_wr || (slave_break && frame_busy)) begin
      abort_flag <= 1'b1;
    end else if (slave_break) begin
      abort_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      data_request_flag <= 1'b0;
    end else if (ident_received && slave && !processing_blocked) begin
      data_request_flag <= 1'b1;
    end else if (data_ack_strobe || stop_wr || break_seen || frame_finished || !slave) begin
      data_request_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_flag <= 1'b0;
    end else if (frame_finished) begin
      done_flag <= 1'b1;
    end else if (frame_begin) begin
      done_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Error flag and fault causes
  // A fault arriving in the same cycle as the clear strobe survives it.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fault_flag <= 1'b0;
      fault_cause_register <= '0;
    end else begin
      fault_flag <= any_fault || (fault_flag && !fault_clear_strobe);
      for (int i = 0; i < LCS_FAULT_BITS; i++) begin
        fault_cause_register[i] <= fault_event[i] || (fault_cause_register[i] && !fault_clear_strobe);
      end
    end
  end

  // ==========================================================================
  // Wakeup flag and pending interrupt
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wakeup_rx_flag <= 1'b0;
    end else if (wakeup_seen) begin
      wakeup_rx_flag <= 1'b1;
    end else if (frame_begin) begin
      wakeup_rx_flag <= 1'b0;
    end
  end

  // Finished frames, faults, received wakeups, idle timeouts and unblocked slave identifiers raise the pending flag; a clear in the same cycle loses to the event.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pending_irq_flag <= 1'b0;
    end else if (frame_finished || any_fault || wakeup_seen || idle_rise ||
                 (ident_received && slave && !processing_blocked)) begin
      pending_irq_flag <= 1'b1;
    end else if (irq_clear_strobe) begin
      pending_irq_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Register images and indirect read port
  // Stop and both clear strobes are never stored, so they read back as zero.
  always_comb begin
    link_control = LCS_CONTROL_RESET;
    link_control[LCS_CTL_SLEEP] = sleep_ctl;
    link_control[LCS_CTL_DIR] = direction_select;
    link_control[LCS_CTL_ACK] = data_ack_strobe;
    link_control[LCS_CTL_WAKE] = wake_request;
    link_control[LCS_CTL_START] = frame_start_request;
  end

  always_comb begin
    link_status = LCS_STATUS_RESET;
    link_status[LCS_ST_ACTIVE] = bus_active;
    link_status[LCS_ST_IDLE] = idle_timeout_flag;
    link_status[LCS_ST_ABORT] = abort_flag;
    link_status[LCS_ST_DREQ] = data_request_flag;
    link_status[LCS_ST_IRQ] = pending_irq_flag;
    link_status[LCS_ST_ERROR] = fault_flag;
    link_status[LCS_ST_WAKEUP] = wake_tx_busy || wakeup_rx_flag;
    link_status[LCS_ST_DONE] = done_flag;
  end

  // Data bytes, size, divider and identifier live elsewhere and read as zero here.
  always_comb begin
    unique case (indirect_pointer)
      LCS_IDX_CONTROL: next_port_data = link_control;
      LCS_IDX_STATUS: next_port_data = link_status;
      LCS_IDX_FAULT: next_port_data = {{(8 - LCS_FAULT_BITS){1'b0}}, fault_cause_register};
      default: next_port_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      port_data <= 8'h00;
    end else if (port_rd) begin
      port_data <= next_port_data;
    end
  end

endmodule

// >>> design/lcs_idle_if.sv
// Interface carrying the idle timer hookup between the control logic and its timer.
interface lcs_idle_if;
  logic run;
  logic activity;
  logic expired;
  modport ctrl (output run, output activity, input expired);
  modport timer (input run, input activity, output expired);
endinterface

// >>> design/lcs_idle_timer.sv
// Bus idle timer that raises a level once the bus has been quiet for the set time.
module lcs_idle_timer
  import lcs_pkg::*;
#(
  parameter longint IDLE_CYCLES = LCS_IDLE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  lcs_idle_if.timer idle
);

  localparam int CW = $clog2(IDLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(IDLE_CYCLES - 1);

  if (IDLE_CYCLES < 1) begin
    $error("lcs_idle_timer: IDLE_CYCLES must be at least 1");
  end

  logic [CW-1:0] count;

  // ==========================================================================
  // Quiet-time counter
  // The counter stops at its last value so the expired level holds until activity returns or run drops.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      idle.expired <= 1'b0;
    end else if (!idle.run || idle.activity) begin
      count <= '0;
      idle.expired <= 1'b0;
    end else if (count == LAST) begin
      idle.expired <= 1'b1;
    end else begin
      count <= count + CW'(1);
    end
  end

endmodule

// >>> design/lcs_pkg.sv
// Package with the register map, field positions and timing constants of the LIN control and status logic.
package lcs_pkg;

  // ==========================================================================
  // Indirect register indices
  localparam logic [7:0] LCS_IDX_CONTROL = 8'h08;
  localparam logic [7:0] LCS_IDX_STATUS = 8'h09;
  localparam logic [7:0] LCS_IDX_FAULT = 8'h0A;

  // ==========================================================================
  // Control register fields
  localparam int LCS_CTL_STOP = 7;
  localparam int LCS_CTL_SLEEP = 6;
  localparam int LCS_CTL_DIR = 5;
  localparam int LCS_CTL_ACK = 4;
  localparam int LCS_CTL_IRQCLR = 3;
  localparam int LCS_CTL_FAULTCLR = 2;
  localparam int LCS_CTL_WAKE = 1;
  localparam int LCS_CTL_START = 0;
  localparam logic [7:0] LCS_CONTROL_RESET = 8'h00;

  // ==========================================================================
  // Status register fields
  localparam int LCS_ST_ACTIVE = 7;
  localparam int LCS_ST_IDLE = 6;
  localparam int LCS_ST_ABORT = 5;
  localparam int LCS_ST_DREQ = 4;
  localparam int LCS_ST_IRQ = 3;
  localparam int LCS_ST_ERROR = 2;
  localparam int LCS_ST_WAKEUP = 1;
  localparam int LCS_ST_DONE = 0;
  localparam logic [7:0] LCS_STATUS_RESET = 8'h00;

  // ==========================================================================
  // Mode configuration register fields and reset value
  localparam int LCS_CFG_ENABLE = 7;
  localparam int LCS_CFG_MASTER = 6;
  localparam int LCS_CFG_AUTOBAUD = 5;
  localparam logic [7:0] LCS_CONFIG_RESET = 8'h60;
  localparam logic [7:0] LCS_CONFIG_MASK = 8'hE0;

  // ==========================================================================
  // Fault cause register holds five cause bits in the low positions
  localparam int LCS_FAULT_BITS = 5;

  // ==========================================================================
  // Bus idle timeout
  localparam longint LCS_IDLE_TIMEOUT_MS = 4000;
  localparam longint LCS_CLOCK_KHZ = 125000;
  localparam longint LCS_IDLE_CYCLES = LCS_IDLE_TIMEOUT_MS * LCS_CLOCK_KHZ;

  // ==========================================================================
  // Frame tracking states
  typedef enum logic [1:0] {
    LCS_IDLE = 2'b00,
    LCS_FRAME = 2'b01,
    LCS_BLOCKED = 2'b10,
    LCS_ASLEEP = 2'b11
  } lcs_state_t;

endpackage

// >>> testbench/lcs_control_status_chk.sv
// Port-level assertions of the LIN control and status logic.
module lcs_control_status_chk
  import lcs_pkg::*;
#(
  parameter longint IDLE_CYCLES = LCS_IDLE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic config_wr,
  input wire logic pointer_wr,
  input wire logic port_wr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] config_data,
  input wire logic [7:0] pointer_data,
  input wire logic bus_active,
  input wire logic break_seen,
  input wire logic ident_received,
  input wire logic frame_finished,
  input wire logic [LCS_FAULT_BITS-1:0] fault_event,
  input wire logic sleep_frame_seen,
  input wire logic wakeup_seen,
  input wire logic wake_tx_finished,
  input wire logic master_mode,
  input wire logic direction_select,
  input wire logic frame_launch,
  input wire logic data_ack_pulse,
  input wire logic wake_launch,
  input wire logic processing_blocked,
  input wire logic sleep_mode,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Helpers
  wire logic ctl_wr = port_wr && pointer_data == LCS_IDX_CONTROL;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Register access
  a_pointer_load: assert property (pointer_wr |=> pointer_data == $past(wr_data))
    else $error("pointer lost its written value");
  a_role_select: assert property (config_wr |=> master_mode == $past(wr_data[6])
    && config_data == ($past(wr_data) & LCS_CONFIG_MASK))
    else $error("mode config not taken");
  a_dir_select: assert property (ctl_wr |=> direction_select == $past(wr_data[LCS_CTL_DIR]))
    else $error("direction not taken");
  a_start_master: assert property (frame_launch |-> $past(ctl_wr && wr_data[0] && master_mode))
    else $error("launch without master start write");
  a_ack_slave: assert property (data_ack_pulse |-> $past(ctl_wr && wr_data[4] && !master_mode))
    else $error("ack pulse without slave ack write");
  a_wake_launch: assert property (wake_launch |-> $past(ctl_wr && wr_data[1]))
    else $error("wake launch without request");
  a_stop_blocks: assert property (ctl_wr && wr_data[7] && !master_mode && !break_seen |=> processing_blocked)
    else $error("stop write did not block");
  a_break_unblocks: assert property (processing_blocked && break_seen && !ctl_wr |=> !processing_blocked)
    else $error("break did not unblock");
  // ==========================================================================
  // Interrupt and sleep
  a_irq_on_event: assert property (frame_finished || fault_event != 5'h00 |=> irq)
    else $error("event did not raise irq");
  a_irq_holds: assert property (irq && !(ctl_wr && wr_data[3]) |=> irq)
    else $error("irq dropped without clear");
  a_irq_clear: assert property (ctl_wr && wr_data[3] && !frame_finished && fault_event == 5'h00
    && !wakeup_seen && !ident_received && (master_mode || bus_active) |=> !irq)
    else $error("irq clear ignored");
  a_sleep_slave: assert property ($rose(sleep_mode) |-> !$past(master_mode))
    else $error("sleep entered in master mode");
  a_wake_ends_sleep: assert property (wake_tx_finished && bus_active && !sleep_frame_seen |=> !sleep_mode)
    else $error("sleep held after wakeup sent");
endmodule

bind lcs_control_status lcs_control_status_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
  .clock, .sys_rst, .config_wr, .pointer_wr, .port_wr, .wr_data, .config_data, .pointer_data, .bus_active,
  .break_seen, .ident_received, .frame_finished, .fault_event, .sleep_frame_seen, .wakeup_seen,
  .wake_tx_finished, .master_mode, .direction_select, .frame_launch, .data_ack_pulse, .wake_launch,
  .processing_blocked, .sleep_mode, .irq
);

// >>> testbench/lcs_control_status_test.sv
// Self-checking testbench of the LIN control and status logic.
module lcs_control_status_test import lcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] EV_BRK = 10'h001;
  localparam logic [9:0] EV_ID = 10'h002;
  localparam logic [9:0] EV_SLP = 10'h004;
  localparam logic [9:0] EV_WUP = 10'h008;
  localparam logic [9:0] EV_TOUT = 10'h040;
  localparam logic [9:0] EV_FIN = 10'h200;
  localparam logic [7:0] I_CT = LCS_IDX_CONTROL;
  localparam logic [7:0] I_ST = LCS_IDX_STATUS;
  localparam logic [7:0] I_FT = LCS_IDX_FAULT;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic config_wr = 1'b0;
  logic pointer_wr = 1'b0;
  logic port_wr = 1'b0;
  logic port_rd = 1'b0;
  logic hold_bus = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] config_data, pointer_data, port_data;
  logic bus_active, break_seen, ident_received, frame_finished, sleep_frame_seen, wakeup_seen;
  logic wake_tx_busy, wake_tx_finished, link_enable, master_mode, direction_select, frame_launch;
  logic data_ack_pulse, wake_launch, processing_blocked, sleep_mode, irq;
  logic [LCS_FAULT_BITS-1:0] fault_event;
  logic [7:0] dirs [2] = '{8'h21, 8'h01};
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  always #4 clock = ~clock;

  lcs_control_status #(.IDLE_CYCLES(20)) dut (
    .clock, .sys_rst, .config_wr, .pointer_wr, .port_wr, .port_rd, .wr_data, .config_data, .pointer_data,
    .port_data, .bus_active, .break_seen, .ident_received, .frame_finished, .fault_event, .sleep_frame_seen,
    .wakeup_seen, .wake_tx_busy, .wake_tx_finished, .link_enable, .master_mode, .direction_select,
    .frame_launch, .data_ack_pulse, .wake_launch, .processing_blocked, .sleep_mode, .irq
  );
  lcs_node_model m (
    .clock, .frame_launch, .wake_launch, .hold_bus, .bus_active, .break_seen, .ident_received,
    .frame_finished, .fault_event, .sleep_frame_seen, .wakeup_seen, .wake_tx_busy, .wake_tx_finished
  );

  // ==========================================================================
  // Access tasks
  task automatic wr(input logic [2:0] s, input logic [7:0] v);
    @(negedge clock);
    {config_wr, pointer_wr, port_wr} = s;
    wr_data = v;
    @(negedge clock);
    {config_wr, pointer_wr, port_wr} = 3'b000;
  endtask
  task automatic wctl(input logic [7:0] v);
    wr(3'b010, I_CT);
    wr(3'b001, v);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    wr(3'b010, idx);
    port_rd = 1'b1;
    @(negedge clock);
    port_rd = 1'b0;
    v = port_data;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] msk, input logic [7:0] exp);
    logic [7:0] v;
    rd(idx, v);
    chk(nm, v & msk, exp);
  endtask
  function automatic logic sig_of(input int w);
    case (w)
      0: return irq;
      1: return sleep_mode;
      default: return bus_active;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic v);
    for (int i = 0; i < 60 && sig_of(w) !== v; i++) @(negedge clock);
  endtask
  task automatic summarize;
    $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // A hang shows up as a cycle count far beyond the few hundred the tests need.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    chk("config", config_data, LCS_CONFIG_RESET);
    rchk("ctl reset", I_CT, 8'hFF, LCS_CONTROL_RESET);
    rchk("st reset", I_ST, 8'hFF, LCS_STATUS_RESET);
    rchk("unmapped", 8'h0F, 8'hFF, 8'h00);
    $display("Test reset finished");
    wr(3'b100, 8'hC0);
    chk("enable", {link_enable, master_mode}, 8'h03);
    // Frame contents sit in the engine, so setting start is the last step.
    foreach (dirs[i]) begin
      wctl(dirs[i]);
      chk("dir", direction_select, dirs[i][5]);
      rchk("st run", I_ST, 8'h81, 8'h80);
      wait_for(0, 1'b1);
      rchk("st end", I_ST, 8'hFF, 8'h09);
      rchk("ctl end", I_CT, 8'hFF, dirs[i] & 8'h20);
      chk("irq set", irq, 8'h01);
      wctl((dirs[i] & 8'h20) | 8'h08);
      rchk("st clr", I_ST, 8'hFF, 8'h01);
      chk("irq clr", irq, 8'h00);
    end
    $display("Test frames finished");
    wctl(8'h01);
    m.pulse(EV_TOUT);
    rchk("ctl err", I_CT, 8'h01, 8'h00);
    rchk("st err", I_ST, 8'h0C, 8'h0C);
    rchk("cause", I_FT, 8'hFF, 8'h04);
    wait_for(2, 1'b0);
    wctl(8'h04);
    rchk("st fclr", I_ST, 8'h04, 8'h00);
    rchk("cause clr", I_FT, 8'hFF, 8'h00);
    wctl(8'hD8);
    chk("blocked m", processing_blocked, 8'h00);
    chk("sleep m", sleep_mode, 8'h00);
    rchk("ctl m", I_CT, 8'hFF, 8'h00);
    rchk("st m", I_ST, 8'hFF, 8'h01);
    $display("Test errors finished");
    wr(3'b100, 8'h80);
    hold_bus = 1'b1;
    m.pulse(EV_BRK);
    m.pulse(EV_ID);
    rchk("st id", I_ST, 8'hFF, 8'h98);
    wctl(8'h10);
    rchk("st ack", I_ST, 8'h10, 8'h00);
    rchk("ctl ack", I_CT, 8'hFF, 8'h00);
    wctl(8'h08);
    m.pulse(EV_ID);
    wctl(8'h80);
    chk("blocked", processing_blocked, 8'h01);
    rchk("st stop", I_ST, 8'h30, 8'h20);
    rchk("ctl stop", I_CT, 8'hFF, 8'h00);
    m.pulse(EV_ID);
    rchk("st blk", I_ST, 8'h10, 8'h00);
    m.pulse(EV_BRK);
    chk("unblocked", processing_blocked, 8'h00);
    rchk("st brk", I_ST, 8'h21, 8'h00);
    m.pulse(EV_BRK);
    rchk("st early", I_ST, 8'h20, 8'h20);
    m.pulse(EV_FIN);
    rchk("st fin", I_ST, 8'h21, 8'h21);
    wctl(8'h08);
    $display("Test slave finished");
    wctl(8'h40);
    m.pulse(EV_SLP);
    chk("sleep cmd", sleep_mode, 8'h01);
    wctl(8'h02);
    rchk("st wtx", I_ST, 8'h02, 8'h02);
    wait_for(1, 1'b0);
    chk("woken", sleep_mode, 8'h00);
    rchk("ctl wake", I_CT, 8'hFF, 8'h00);
    wctl(8'h40);
    hold_bus = 1'b0;
    wait_for(1, 1'b1);
    chk("sleep idle", sleep_mode, 8'h01);
    chk("irq idle", irq, 8'h01);
    wctl(8'h08);
    m.pulse(EV_WUP);
    chk("wake rx", sleep_mode, 8'h00);
    repeat (24) @(negedge clock);
    rchk("st wrx", I_ST, 8'h42, 8'h42);
    $display("Test sleep finished");
    summarize();
  end
endmodule

// >>> testbench/lcs_node_model.sv
// Far-side model standing in for the frame engine and the other nodes on the LIN wire.
module lcs_node_model
  import lcs_pkg::*;
(
  input wire logic clock,
  input wire logic frame_launch,
  input wire logic wake_launch,
  input wire logic hold_bus,
  output logic bus_active,
  output logic break_seen,
  output logic ident_received,
  output logic frame_finished,
  output logic [LCS_FAULT_BITS-1:0] fault_event,
  output logic sleep_frame_seen,
  output logic wakeup_seen,
  output logic wake_tx_busy,
  output logic wake_tx_finished
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] kick = 10'h000;
  logic [3:0] frame_cnt = 4'h0;
  logic [2:0] wake_cnt = 3'h0;
  logic fin = 1'b0;
  logic wfin = 1'b0;
  assign wake_tx_finished = wfin;
  // Slave-side events come only when the bench asks for them.
  assign {frame_finished, fault_event, wakeup_seen, sleep_frame_seen, ident_received, break_seen} = kick | {fin, 9'h000};
  assign wake_tx_busy = wake_cnt != 3'h0;
  // The wakeup signal is bus traffic too, so it keeps the idle timer quiet.
  assign bus_active = hold_bus || frame_cnt != 4'h0 || wake_tx_busy || wake_tx_finished;
  always @(negedge clock) begin
    fin <= frame_cnt == 4'h1;
    wfin <= wake_cnt == 3'h1;
    if (frame_launch) begin
      frame_cnt <= 4'hA;
    end else if (frame_cnt != 4'h0) begin
      frame_cnt <= frame_cnt - 4'h1;
    end
    if (wake_launch) begin
      wake_cnt <= 3'h4;
    end else if (wake_cnt != 3'h0) begin
      wake_cnt <= wake_cnt - 3'h1;
    end
  end
  task automatic pulse(input logic [9:0] k);
    @(negedge clock);
    kick = k;
    @(negedge clock);
    kick = 10'h000;
  endtask
endmodule
